// ### rtl/hot_swap_gpio_pkg.sv
// constants, field layout and carriers for the hot swap gpio status block
// Notes on behaviour
// RQ1: writing 1 to driver-enable clear bits 19:16 makes that pin input only
// RQ2: writing 1 to driver-enable set bits 23:20 enables that pin's driver
// RQ3: after reset both driver-enable fields read zero, all pins input only
// RQ4: zero bits in set/clear fields change nothing; reads return last written value
// RQ5: pin level bits 31:28 are read-only, updated the clock after a pin change
// RQ6: bits 27:24 of the pin level byte read as zero
// RQ7: writing 1 to output clear bits 11:8 drives that pin low if bidirectional
// RQ8: writing 1 to output set bits 15:12 drives that pin high if bidirectional
// RQ9: new output data reaches the pins on the clock after the write
// RQ10: input-only pins are never driven, whatever output data holds
// RQ11: all three registers share dword 64h, selected by active-low byte enables
// RQ12: pin 2 extraction, pin 3 insertion, pin 0 removal led, pin 1 irq mask
// RQ13: host keeps pins 2 and 3 as inputs, never enabling their drivers
// RQ14: opening the extractor handle starts raising the enumeration interrupt
// RQ15: enumeration interrupt is active low, flags pending extraction or fresh insertion
// RQ16: once pmc supply is stable, reset is held to the pmc slots
// RQ17: setting the led control bit lights the safe-to-remove led
// RQ18: while the mask bit is set, the enumeration interrupt stays deasserted
package hot_swap_gpio_pkg;

	localparam logic [7:0] GPIO_DWORD_ADDR = 8'h64;
	localparam logic [7:0] OUT_VALUE_OFFSET = 8'h65;
	localparam logic [7:0] DRV_ENABLE_OFFSET = 8'h66;
	localparam logic [7:0] PIN_LEVELS_OFFSET = 8'h67;

	localparam int OUT_VALUE_LANE = 1;
	localparam int DRV_ENABLE_LANE = 2;
	localparam int PIN_LEVELS_LANE = 3;

	localparam int OUT_CLR_LSB = 8;
	localparam int OUT_SET_LSB = 12;
	localparam int DRV_CLR_LSB = 16;
	localparam int DRV_SET_LSB = 20;
	localparam int PIN_RSVD_LSB = 24;
	localparam int PIN_LEVEL_LSB = 28;

	localparam int LED_PIN = 0;
	localparam int MASK_PIN = 1;
	localparam int EXT_PIN = 2;
	localparam int INS_PIN = 3;

	localparam logic [3:0] FIELD_RESET = 4'h0;
	localparam logic [3:0] RSVD_VALUE = 4'h0;

	localparam int CLK_MHZ = 40;
	localparam int PMC_RST_US = 1000;
	localparam int PMC_RST_CYCLES = PMC_RST_US * CLK_MHZ;

	typedef enum logic [1:0] {
		PWR_OFF,
		PWR_RESET,
		PWR_RUN
	} power_state_e;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] dword_addr;
		logic [3:0] be_n;
		logic [31:0] wdata;
	} cfg_req_s;

	typedef struct packed {
		logic [3:0] level;
		logic [3:0] enable;
	} gpio_drive_s;

endpackage : hot_swap_gpio_pkg

// ### rtl/hot_swap_gpio_status.sv
// gpio bank at config dword 64h plus hot swap board logic for a pmc carrier
`timescale 1ns/100ps
module hot_swap_gpio_status #(
	parameter int PMC_RST_CYCLES = hot_swap_gpio_pkg::PMC_RST_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// configuration access
	input wire hot_swap_gpio_pkg::cfg_req_s cfg_req,
	output logic [31:0] cfg_rdata_q,
	output logic cfg_rvalid_q,
	// gpio pins, three signals each
	input wire logic [3:0] gpio_in,
	output hot_swap_gpio_pkg::gpio_drive_s gpio_q,
	// hot swap board signals
	input wire logic handle_open,
	input wire logic pmc_power_good,
	output logic enum_n_q,
	output logic removal_led_on_q,
	output logic pmc_rst_n_q
);

	logic [3:0] drv_en_q;
	logic [3:0] drv_en_d;
	logic [3:0] out_val_q;
	logic [3:0] out_val_d;
	logic [3:0] drv_clr_wr_q;
	logic [3:0] drv_set_wr_q;
	logic [3:0] out_clr_wr_q;
	logic [3:0] out_set_wr_q;
	logic [3:0] pin_levels_q;
	logic [3:0] pin_view;
	logic hit;
	logic out_wr;
	logic drv_wr;
	logic extraction_flag_q;
	logic insertion_flag_q;
	logic mask_seen_q;
	logic removal_irq_mask;
	logic [31:0] rdata_d;
	logic [31:0] rst_cnt_q;
	hot_swap_gpio_pkg::power_state_e pwr_state_q;

	// one nibble of a set/clear field pair: set beats clear on the same bit
	function automatic logic [3:0] set_clear(
		input logic [3:0] cur,
		input logic [3:0] set_bits,
		input logic [3:0] clr_bits
	);
		set_clear = (cur & ~clr_bits) | set_bits;
	endfunction : set_clear

	assign hit = cfg_req.dword_addr == hot_swap_gpio_pkg::GPIO_DWORD_ADDR;
	assign out_wr = hit && cfg_req.wr && !cfg_req.be_n[hot_swap_gpio_pkg::OUT_VALUE_LANE]; // [RQ11]
	assign drv_wr = hit && cfg_req.wr && !cfg_req.be_n[hot_swap_gpio_pkg::DRV_ENABLE_LANE]; // [RQ11]

	always_comb
	begin
		drv_en_d = drv_en_q;
		out_val_d = out_val_q;
		if (drv_wr)
		begin
			// zero bits leave the enable untouched [RQ4]
			drv_en_d = set_clear(drv_en_q,
				cfg_req.wdata[hot_swap_gpio_pkg::DRV_SET_LSB +: 4], // [RQ2]
				cfg_req.wdata[hot_swap_gpio_pkg::DRV_CLR_LSB +: 4]); // [RQ1]
		end
		if (out_wr)
		begin
			out_val_d = set_clear(out_val_q,
				cfg_req.wdata[hot_swap_gpio_pkg::OUT_SET_LSB +: 4], // [RQ8]
				cfg_req.wdata[hot_swap_gpio_pkg::OUT_CLR_LSB +: 4]); // [RQ7]
		end
	end

	// driver enables and output values
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			drv_en_q <= hot_swap_gpio_pkg::FIELD_RESET; // [RQ3]
			out_val_q <= hot_swap_gpio_pkg::FIELD_RESET;
		end
		else
		begin
			drv_en_q <= drv_en_d;
			out_val_q <= out_val_d;
		end
	end

	// last written field values, returned on read
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			drv_clr_wr_q <= hot_swap_gpio_pkg::FIELD_RESET; // [RQ3]
			drv_set_wr_q <= hot_swap_gpio_pkg::FIELD_RESET; // [RQ3]
			out_clr_wr_q <= hot_swap_gpio_pkg::FIELD_RESET;
			out_set_wr_q <= hot_swap_gpio_pkg::FIELD_RESET;
		end
		else
		begin
			if (drv_wr)
			begin
				drv_clr_wr_q <= cfg_req.wdata[hot_swap_gpio_pkg::DRV_CLR_LSB +: 4]; // [RQ4]
				drv_set_wr_q <= cfg_req.wdata[hot_swap_gpio_pkg::DRV_SET_LSB +: 4]; // [RQ4]
			end
			if (out_wr)
			begin
				out_clr_wr_q <= cfg_req.wdata[hot_swap_gpio_pkg::OUT_CLR_LSB +: 4]; // [RQ4]
				out_set_wr_q <= cfg_req.wdata[hot_swap_gpio_pkg::OUT_SET_LSB +: 4]; // [RQ4]
			end
		end
	end

	// pin drivers follow the next-state so data shows the cycle after the write
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			gpio_q <= '0; // [RQ3]
		end
		else
		begin
			gpio_q.enable <= drv_en_d; // [RQ2]
			gpio_q.level <= out_val_d & drv_en_d; // [RQ9] [RQ10]
		end
	end

	// pin view: driven pins read back their own value; 2 and 3 come from board logic
	always_comb
	begin
		pin_view = (drv_en_q & out_val_q) | (~drv_en_q & gpio_in);
		pin_view[hot_swap_gpio_pkg::EXT_PIN] = extraction_flag_q; // [RQ12]
		pin_view[hot_swap_gpio_pkg::INS_PIN] = insertion_flag_q; // [RQ12]
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_levels_q <= hot_swap_gpio_pkg::FIELD_RESET;
		end
		else
		begin
			pin_levels_q <= pin_view; // [RQ5]
		end
	end

	// read data: only enabled lanes, lane 0 and other dwords read zero
	always_comb
	begin
		rdata_d = '0;
		if (hit)
		begin
			if (!cfg_req.be_n[hot_swap_gpio_pkg::OUT_VALUE_LANE])
			begin
				rdata_d[hot_swap_gpio_pkg::OUT_CLR_LSB +: 4] = out_clr_wr_q; // [RQ4]
				rdata_d[hot_swap_gpio_pkg::OUT_SET_LSB +: 4] = out_set_wr_q; // [RQ4]
			end
			if (!cfg_req.be_n[hot_swap_gpio_pkg::DRV_ENABLE_LANE])
			begin
				rdata_d[hot_swap_gpio_pkg::DRV_CLR_LSB +: 4] = drv_clr_wr_q; // [RQ4]
				rdata_d[hot_swap_gpio_pkg::DRV_SET_LSB +: 4] = drv_set_wr_q; // [RQ4]
			end
			if (!cfg_req.be_n[hot_swap_gpio_pkg::PIN_LEVELS_LANE])
			begin
				rdata_d[hot_swap_gpio_pkg::PIN_RSVD_LSB +: 4] = hot_swap_gpio_pkg::RSVD_VALUE; // [RQ6]
				rdata_d[hot_swap_gpio_pkg::PIN_LEVEL_LSB +: 4] = pin_levels_q; // [RQ5] [RQ11]
			end
		end
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			cfg_rdata_q <= '0;
			cfg_rvalid_q <= 1'b0;
		end
		else
		begin
			cfg_rdata_q <= cfg_req.rd ? rdata_d : '0;
			cfg_rvalid_q <= cfg_req.rd;
		end
	end

	// pmc power sequencing
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pwr_state_q <= hot_swap_gpio_pkg::PWR_OFF;
			rst_cnt_q <= '0;
			pmc_rst_n_q <= 1'b0;
		end
		else
		begin
			case (pwr_state_q)
				hot_swap_gpio_pkg::PWR_OFF:
				begin
					pmc_rst_n_q <= 1'b0;
					rst_cnt_q <= '0;
					if (pmc_power_good)
					begin
						pwr_state_q <= hot_swap_gpio_pkg::PWR_RESET;
					end
				end
				hot_swap_gpio_pkg::PWR_RESET:
				begin
					pmc_rst_n_q <= 1'b0; // [RQ16]
					if (!pmc_power_good)
					begin
						pwr_state_q <= hot_swap_gpio_pkg::PWR_OFF;
					end
					else if (rst_cnt_q == 32'(PMC_RST_CYCLES - 1))
					begin
						pwr_state_q <= hot_swap_gpio_pkg::PWR_RUN;
						pmc_rst_n_q <= 1'b1;
					end
					else
					begin
						rst_cnt_q <= rst_cnt_q + 32'h0000_0001;
					end
				end
				hot_swap_gpio_pkg::PWR_RUN:
				begin
					pmc_rst_n_q <= pmc_power_good;
					if (!pmc_power_good)
					begin
						pwr_state_q <= hot_swap_gpio_pkg::PWR_OFF;
					end
				end
				default:
				begin
					pwr_state_q <= hot_swap_gpio_pkg::PWR_OFF;
					pmc_rst_n_q <= 1'b0;
				end
			endcase
		end
	end

	assign removal_irq_mask = pin_view[hot_swap_gpio_pkg::MASK_PIN]; // [RQ12]

	// extraction follows the handle; insertion is raised when the pmc leaves reset
	// and dropped when software sets the mask as acknowledgement or the handle opens
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			extraction_flag_q <= 1'b0;
			insertion_flag_q <= 1'b0;
			mask_seen_q <= 1'b0;
		end
		else
		begin
			extraction_flag_q <= handle_open; // [RQ14]
			mask_seen_q <= removal_irq_mask;
			if (pwr_state_q == hot_swap_gpio_pkg::PWR_RESET
				&& rst_cnt_q == 32'(PMC_RST_CYCLES - 1) && pmc_power_good)
			begin
				insertion_flag_q <= 1'b1;
			end
			else if ((removal_irq_mask && !mask_seen_q) || handle_open)
			begin
				insertion_flag_q <= 1'b0;
			end
		end
	end

	// enumeration interrupt and removal led
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			enum_n_q <= 1'b1;
			removal_led_on_q <= 1'b0;
		end
		else
		begin
			enum_n_q <= !((extraction_flag_q || insertion_flag_q) && !removal_irq_mask); // [RQ15] [RQ18]
			removal_led_on_q <= pin_view[hot_swap_gpio_pkg::LED_PIN]; // [RQ17]
		end
	end

endmodule : hot_swap_gpio_status

// ### tb/cfg_host.sv
// host model issuing configuration cycles to the gpio dword
`timescale 1ns/100ps
module cfg_host (
	// clock
	input wire logic clk,
	// configuration bus
	output hot_swap_gpio_pkg::cfg_req_s cfg_req,
	input wire logic [31:0] cfg_rdata_q,
	input wire logic cfg_rvalid_q
);
	initial cfg_req = '0;

	// one strobe cycle, then the bus is released with scrambled fields
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		@(posedge clk);
		cfg_req <= '{1'b1, 1'b0, a, be, d};
		@(posedge clk);
		cfg_req <= '{1'b0, 1'b0, ~a, ~be, ~d};
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [3:0] be, output logic [31:0] q,
		output bit ok);
		@(posedge clk);
		cfg_req <= '{1'b0, 1'b1, a, be, 32'h0000_0000};
		@(posedge clk);
		cfg_req <= '{1'b0, 1'b0, ~a, ~be, 32'hffff_ffff};
		ok = 0;
		for (int i = 0; i < 4 && !ok; i++)
		begin
			@(posedge clk);
			ok = (cfg_rvalid_q === 1'b1);
		end
		q = cfg_rdata_q;
	endtask : rd
endmodule : cfg_host

// ### tb/hot_swap_gpio_status_checker.sv
// assertions on the ports of the hot swap gpio block
`timescale 1ns/100ps
module hot_swap_gpio_status_checker #(
	parameter int PMC_RST_CYCLES = hot_swap_gpio_pkg::PMC_RST_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// configuration access
	input wire hot_swap_gpio_pkg::cfg_req_s cfg_req,
	input wire logic [31:0] cfg_rdata_q,
	input wire logic cfg_rvalid_q,
	// pins and board signals
	input wire logic [3:0] gpio_in,
	input wire hot_swap_gpio_pkg::gpio_drive_s gpio_q,
	input wire logic handle_open,
	input wire logic pmc_power_good,
	input wire logic enum_n_q,
	input wire logic removal_led_on_q,
	input wire logic pmc_rst_n_q
);
	logic mask;
	logic oe_wr;
	int pg_q;
	assign mask = gpio_q.enable[1] ? gpio_q.level[1] : gpio_in[1];
	assign oe_wr = cfg_req.wr && cfg_req.dword_addr == 8'h64 && !cfg_req.be_n[2];
	// cycles for which power good has been high
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			pg_q <= 0;
		else
			pg_q <= pmc_power_good ? pg_q + 1 : 0;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_rvalid; cfg_req.rd |=> cfg_rvalid_q; endproperty
	property p_quiet; !cfg_req.rd |=> !cfg_rvalid_q && cfg_rdata_q == 32'h0; endproperty
	property p_rsvd; cfg_rvalid_q |-> cfg_rdata_q[27:24] == 4'h0; endproperty
	property p_oe_set;
		oe_wr |=> (gpio_q.enable & $past(cfg_req.wdata[23:20])) == $past(cfg_req.wdata[23:20]);
	endproperty
	property p_oe_clr;
		oe_wr |=> (gpio_q.enable & $past(cfg_req.wdata[19:16]) & ~$past(cfg_req.wdata[23:20]))
			== 4'h0;
	endproperty
	property p_oe_hold; !oe_wr |=> $stable(gpio_q.enable); endproperty
	property p_undriven; gpio_q.level != 4'h0 |-> (gpio_q.level & ~gpio_q.enable) == 4'h0;
	endproperty
	property p_mask; mask [*3] |-> enum_n_q; endproperty
	property p_handle; (handle_open && !mask) [*4] |-> !enum_n_q; endproperty
	property p_pmc_off; !pmc_power_good |=> !pmc_rst_n_q; endproperty
	property p_pmc_on;
		$rose(pmc_rst_n_q) |-> pg_q >= PMC_RST_CYCLES && pg_q <= PMC_RST_CYCLES + 2;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("read not answered");
	a_quiet: assert property (p_quiet) else $error("stray read data");
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	a_oe_set: assert property (p_oe_set) else $error("enable not set");
	a_oe_clr: assert property (p_oe_clr) else $error("enable not cleared");
	a_oe_hold: assert property (p_oe_hold) else $error("enable moved");
	a_undriven: assert property (p_undriven) else $error("input pin driven");
	a_mask: assert property (p_mask) else $error("masked interrupt");
	a_handle: assert property (p_handle) else $error("no interrupt");
	a_pmc_off: assert property (p_pmc_off) else $error("slot reset lost");
	a_pmc_on: assert property (p_pmc_on) else $error("slot reset timing");
	c_read: cover property (cfg_req.rd ##1 cfg_rvalid_q);
	c_pmc: cover property ($rose(pmc_rst_n_q));
	c_enum: cover property ($fell(enum_n_q));
endmodule : hot_swap_gpio_status_checker

bind hot_swap_gpio_status hot_swap_gpio_status_checker #(.PMC_RST_CYCLES(PMC_RST_CYCLES))
	i_checker (.clk(clk), .sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_rdata_q(cfg_rdata_q),
	.cfg_rvalid_q(cfg_rvalid_q), .gpio_in(gpio_in), .gpio_q(gpio_q), .handle_open(handle_open),
	.pmc_power_good(pmc_power_good), .enum_n_q(enum_n_q), .removal_led_on_q(removal_led_on_q),
	.pmc_rst_n_q(pmc_rst_n_q));

// ### tb/tb_top.sv
// self-checking bench for the hot swap gpio block
`timescale 1ns/100ps
module tb_top;
	localparam int RST_N = 8;
	logic clk;
	logic sys_rst;
	logic [3:0] gpio_in;
	logic handle_open;
	logic pmc_power_good;
	hot_swap_gpio_pkg::cfg_req_s cfg_req;
	hot_swap_gpio_pkg::gpio_drive_s gpio_q;
	logic [31:0] rdata;
	logic rvalid;
	logic enum_n_q;
	logic led;
	logic pmc_rst_n_q;
	int n_mismatch;
	int num_checks;
	int seed;
	int k;
	logic [3:0] oe;
	logic [3:0] od;
	logic [15:0] lastw;
	logic insertion_flag;

	cfg_host i_cfg_host (.clk(clk), .cfg_req(cfg_req), .cfg_rdata_q(rdata), .cfg_rvalid_q(rvalid));
	hot_swap_gpio_status #(.PMC_RST_CYCLES(RST_N)) i_hot_swap_gpio_status (.clk(clk),
		.sys_rst(sys_rst), .cfg_req(cfg_req), .cfg_rdata_q(rdata), .cfg_rvalid_q(rvalid),
		.gpio_in(gpio_in), .gpio_q(gpio_q), .handle_open(handle_open),
		.pmc_power_good(pmc_power_good), .enum_n_q(enum_n_q), .removal_led_on_q(led),
		.pmc_rst_n_q(pmc_rst_n_q));

	initial
	begin
		clk = 0;
		forever #12.5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim

	function automatic logic [3:0] view();
		return (oe & od) | (~oe & gpio_in);
	endfunction : view

	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		i_cfg_host.wr(a, be, d);
		if (a == 8'h64 && !be[1])
		begin
			lastw[7:0] = d[15:8];
			od = (od & ~d[11:8]) | d[15:12];
		end
		if (a == 8'h64 && !be[2])
		begin
			lastw[15:8] = d[23:16];
			oe = (oe & ~d[19:16]) | d[23:20];
		end
	endtask : wr

	task automatic rd_cmp(input logic [7:0] a, input logic [3:0] be);
		logic [31:0] q;
		logic [31:0] e;
		logic [3:0] v;
		bit ok;
		v = view();
		e = (a == 8'h64) ? {insertion_flag, handle_open, v[1:0], 4'h0, lastw, 8'h00} : 32'h0;
		for (int i = 0; i < 4; i++)
			if (be[i])
				e[i*8 +: 8] = 8'h00;
		i_cfg_host.rd(a, be, q, ok);
		chk("rvalid", 32'(ok), 32'h1);
		chk("rdata", q, e);
		if (!ok)
			end_sim();
	endtask : rd_cmp

	task automatic pins_cmp(input logic en);
		logic [3:0] v;
		repeat (3) @(posedge clk);
		#1;
		v = view();
		chk("enable", 32'(gpio_q.enable), 32'(oe));
		chk("level", 32'(gpio_q.level), 32'(oe & od));
		chk("led", 32'(led), 32'(v[0]));
		chk("enum", 32'(enum_n_q), 32'(en));
	endtask : pins_cmp

	initial
	begin
		seed = 4638;
		n_mismatch = 0;
		num_checks = 0;
		sys_rst = 1;
		gpio_in = 0;
		handle_open = 0;
		pmc_power_good = 0;
		{oe, od, lastw, insertion_flag} = '0;
		repeat (6) @(posedge clk);
		sys_rst <= 0;
		pins_cmp(1);
		rd_cmp(8'h64, 4'h0);
		$display("test reset done");
		for (int n = 0; n < 40; n++)
		begin
			gpio_in <= 4'($random(seed));
			// drivers of pins 2 and 3 stay off
			wr((n % 5 == 0) ? 8'($random(seed)) : 8'h64, 4'($random(seed)),
				32'($random(seed)) & 32'h0033_ff00);
			pins_cmp(1);
			rd_cmp((n % 7 == 0) ? 8'h60 : 8'h64, 4'($random(seed)));
		end
		$display("test registers done");
		for (int m = 1; m >= 0; m--)
		begin
			wr(8'h64, 4'b1001, m ? 32'h0020_2000 : 32'h0020_0200);
			handle_open <= 1;
			pins_cmp(m[0]);
			rd_cmp(8'h64, 4'b0111);
			handle_open <= 0;
			pins_cmp(1);
		end
		$display("test handle done");
		@(posedge clk);
		pmc_power_good <= 1;
		k = 0;
		while (k < 40 && pmc_rst_n_q !== 1'b1)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("rst_cnt", 32'(k), 32'(RST_N + 1));
		if (k >= 40)
			end_sim();
		insertion_flag = 1;
		pins_cmp(0);
		rd_cmp(8'h64, 4'b0111);
		// raising the mask pin acknowledges the insertion
		wr(8'h64, 4'b1101, 32'h0000_2000);
		insertion_flag = 0;
		pins_cmp(1);
		rd_cmp(8'h64, 4'b0111);
		pmc_power_good <= 0;
		repeat (2) @(posedge clk);
		#1;
		chk("pmc_rst", 32'(pmc_rst_n_q), 32'h0);
		$display("test power done");
		@(posedge clk);
		sys_rst <= 1;
		repeat (2) @(posedge clk);
		sys_rst <= 0;
		{oe, od, lastw, insertion_flag} = '0;
		pins_cmp(1);
		rd_cmp(8'h64, 4'h0);
		$display("test second reset done");
		end_sim();
	end
endmodule : tb_top
